// file: rtl/ohcirc_pkg.sv
package ohcirc_pkg;

  // register offsets, byte addresses from the function memory base
  localparam logic [7:0] OFS_REVISION = 8'h00;
  localparam logic [7:0] OFS_CONTROL  = 8'h04;

  // revision register layout
  localparam logic [7:0] SPEC_VERSION   = 8'h10;
  localparam int         REV_VER_LSB    = 0;
  localparam int         REV_LEGACY_BIT = 8;

  // control register layout
  localparam int CTL_RATIO_LSB    = 0;
  localparam int CTL_PERIODIC_BIT = 2;
  localparam int CTL_ISO_BIT      = 3;
  localparam int CTL_CTRL_LE_BIT  = 4;
  localparam int CTL_BULK_BIT     = 5;
  localparam int CTL_FS_LSB       = 6;
  localparam int CTL_ROUTE_BIT    = 8;
  localparam int CTL_WCONN_BIT    = 9;
  localparam int CTL_WEN_BIT      = 10;

  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_KEEP_M = 32'h0000_07FF;

  // functional state encodings
  typedef enum logic [1:0] {
    OHCIRC_FS_RESET       = 2'h0,
    OHCIRC_FS_RESUME      = 2'h1,
    OHCIRC_FS_OPERATIONAL = 2'h2,
    OHCIRC_FS_SUSPEND     = 2'h3
  } ohcirc_fs_t;

  // timing
  localparam int CLK_PERIOD_PS = 40_000;
  localparam int SOF_DELAY_US  = 1_000;
  localparam int SOF_DELAY_CYCLES =
    (SOF_DELAY_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : ohcirc_pkg

// file: rtl/ohcirc_regs.sv
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - revision low byte reads version 0x10
// - bit 8 legacy flag per function; rest zero
// - only state changes by hardware, on port resume
// - wake-up when enable and resume-detected set
// - wake-connected cleared by hardware reset only
// - routing bit selects normal or management interrupt
// - routing bit survives software reset
// - functional state held in bits 7:6
// - control register at offset 0x04
// - software reset suspends; hardware reset resets ports
// - start-of-frame begins 1 ms after operational entry
module ohcirc_regs #(
  parameter bit FIRST_FUNCTION   = 1'b1,
  parameter int SOF_DELAY_CYCLES = ohcirc_pkg::SOF_DELAY_CYCLES
) (
  // clock and hardware reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // software reset request, one-cycle pulse
  input  wire logic        soft_reset_i,
  // register access port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [3:0]  reg_be_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  // events from the rest of the controller
  input  wire logic        resume_detected_i,
  input  wire logic        event_irq_i,
  input  wire logic        port_resume_i,
  // outputs to system and ports
  output logic             remote_wakeup_o,
  output logic             host_irq_o,
  output logic             smi_o,
  output logic             port_reset_o,
  output logic             sof_start_o,
  output logic             sof_enable_o,
  // control fields for the schedule engine
  output logic [1:0]       ctrl_bulk_ratio_o,
  output logic             periodic_list_enable_o,
  output logic             iso_enable_o,
  output logic             control_list_enable_o,
  output logic             bulk_list_enable_o,
  output logic [1:0]       functional_state_o
);

  generate
    if (SOF_DELAY_CYCLES < 1) begin : g_bad
      $error("ohcirc_regs: SOF_DELAY_CYCLES must be at least 1");
    end
    if (ohcirc_pkg::CTL_WEN_BIT > 10) begin : g_bad_map
      $error("ohcirc_regs: control fields must sit below bit 11");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction : hit

  logic wr_ctl;
  logic rd_rev;
  logic rd_ctl;

  assign wr_ctl = reg_wr_i && hit(reg_addr_i, ohcirc_pkg::OFS_CONTROL);
  assign rd_rev = hit(reg_addr_i, ohcirc_pkg::OFS_REVISION);
  assign rd_ctl = hit(reg_addr_i, ohcirc_pkg::OFS_CONTROL);

  logic wr_ctl_lo;
  logic wr_ctl_hi;

  // lanes 2 and 3 carry only reserved bits, so they get no strobe
  assign wr_ctl_lo = wr_ctl && reg_be_i[0];
  assign wr_ctl_hi = wr_ctl && reg_be_i[1];

  //////////////////////////////////////////////////////////////////////////
  // control register storage

  logic [1:0]         ctrl_bulk_ratio;
  logic               periodic_list_enable;
  logic               iso_enable;
  logic               control_list_enable;
  logic               bulk_list_enable;
  ohcirc_pkg::ohcirc_fs_t functional_state;
  logic               interrupt_routing;
  logic               wakeup_connected;
  logic               wakeup_enable;

  // driver-owned fields; software reset clears all of them
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_bulk_ratio      <= 2'h0;
      periodic_list_enable <= 1'b0;
      iso_enable           <= 1'b0;
      control_list_enable  <= 1'b0;
      bulk_list_enable     <= 1'b0;
      wakeup_enable        <= 1'b0;
    end else if (soft_reset_i) begin
      ctrl_bulk_ratio      <= 2'h0;
      periodic_list_enable <= 1'b0;
      iso_enable           <= 1'b0;
      control_list_enable  <= 1'b0;
      bulk_list_enable     <= 1'b0;
      wakeup_enable        <= 1'b0;
    end else if (wr_ctl) begin
      if (reg_be_i[0]) begin
        ctrl_bulk_ratio      <= reg_wdata_i[ohcirc_pkg::CTL_RATIO_LSB +: 2];
        periodic_list_enable <= reg_wdata_i[ohcirc_pkg::CTL_PERIODIC_BIT];
        iso_enable           <= reg_wdata_i[ohcirc_pkg::CTL_ISO_BIT];
        control_list_enable  <= reg_wdata_i[ohcirc_pkg::CTL_CTRL_LE_BIT];
        bulk_list_enable     <= reg_wdata_i[ohcirc_pkg::CTL_BULK_BIT];
      end
      if (reg_be_i[1]) begin
        wakeup_enable <= reg_wdata_i[ohcirc_pkg::CTL_WEN_BIT];
      end
    end
  end

  // routing tag and wake-connected keep their value over software reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      interrupt_routing <= 1'b0;
      wakeup_connected  <= 1'b0;
    end else if (wr_ctl_hi) begin
      interrupt_routing <= reg_wdata_i[ohcirc_pkg::CTL_ROUTE_BIT];
      wakeup_connected  <= reg_wdata_i[ohcirc_pkg::CTL_WCONN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // functional state

  // driver write wins over a resume seen in the same cycle; the resume is
  // only honoured while suspended, matching the hardware-owned transition
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      functional_state <= ohcirc_pkg::OHCIRC_FS_RESET;
    end else if (soft_reset_i) begin
      functional_state <= ohcirc_pkg::OHCIRC_FS_SUSPEND;
    end else if (wr_ctl_lo) begin
      functional_state <= ohcirc_pkg::ohcirc_fs_t'(
        reg_wdata_i[ohcirc_pkg::CTL_FS_LSB +: 2]);
    end else begin
      case (functional_state)
        ohcirc_pkg::OHCIRC_FS_SUSPEND: begin
          if (port_resume_i) begin
            functional_state <= ohcirc_pkg::OHCIRC_FS_RESUME;
          end
        end
        ohcirc_pkg::OHCIRC_FS_RESET,
        ohcirc_pkg::OHCIRC_FS_RESUME,
        ohcirc_pkg::OHCIRC_FS_OPERATIONAL: begin
          functional_state <= functional_state;
        end
        default: begin
          functional_state <= ohcirc_pkg::OHCIRC_FS_RESET;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // start-of-frame delay

  logic prev_operational;
  logic is_operational;
  logic enter_operational;
  logic sof_done;

  assign is_operational    = (functional_state == ohcirc_pkg::OHCIRC_FS_OPERATIONAL);
  assign enter_operational = is_operational && !prev_operational;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_operational <= 1'b0;
    end else begin
      prev_operational <= is_operational;
    end
  end

  ohcirc_sof_timer #(
    .DELAY_CYCLES (SOF_DELAY_CYCLES)
  ) u_sof_timer (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .start_i   (enter_operational),
    .abort_i   (!is_operational),
    .done_o    (sof_done),
    .running_o ()
  );

  // frames stop as soon as the controller leaves operational
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sof_enable_o <= 1'b0;
      sof_start_o  <= 1'b0;
    end else begin
      sof_start_o <= sof_done && is_operational;
      if (!is_operational) begin
        sof_enable_o <= 1'b0;
      end else if (sof_done) begin
        sof_enable_o <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // system outputs

  // enable never touches the interrupt path
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      remote_wakeup_o <= 1'b0;
    end else begin
      remote_wakeup_o <= wakeup_enable && resume_detected_i;
    end
  end

  // exactly one of the two interrupt lines follows the event
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_irq_o <= 1'b0;
      smi_o      <= 1'b0;
    end else begin
      host_irq_o <= event_irq_i && !interrupt_routing;
      smi_o      <= event_irq_i && interrupt_routing;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      port_reset_o <= 1'b0;
    end else begin
      port_reset_o <= (functional_state == ohcirc_pkg::OHCIRC_FS_RESET);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] rev_word;
  logic [31:0] ctl_word;

  always_comb begin
    rev_word = 32'h0000_0000;
    rev_word[ohcirc_pkg::REV_VER_LSB +: 8] = ohcirc_pkg::SPEC_VERSION;
    rev_word[ohcirc_pkg::REV_LEGACY_BIT]   = FIRST_FUNCTION;
  end

  // reserved bits are not stored, so they always read as zero
  always_comb begin
    ctl_word = ohcirc_pkg::CONTROL_RESET;
    ctl_word[ohcirc_pkg::CTL_RATIO_LSB +: 2] = ctrl_bulk_ratio;
    ctl_word[ohcirc_pkg::CTL_PERIODIC_BIT]   = periodic_list_enable;
    ctl_word[ohcirc_pkg::CTL_ISO_BIT]        = iso_enable;
    ctl_word[ohcirc_pkg::CTL_CTRL_LE_BIT]    = control_list_enable;
    ctl_word[ohcirc_pkg::CTL_BULK_BIT]       = bulk_list_enable;
    ctl_word[ohcirc_pkg::CTL_FS_LSB +: 2]    = functional_state;
    ctl_word[ohcirc_pkg::CTL_ROUTE_BIT]      = interrupt_routing;
    ctl_word[ohcirc_pkg::CTL_WCONN_BIT]      = wakeup_connected;
    ctl_word[ohcirc_pkg::CTL_WEN_BIT]        = wakeup_enable;
    ctl_word = ctl_word & ohcirc_pkg::CONTROL_KEEP_M;
  end

  // revision has no write path at all, so a write there does nothing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (rd_rev) begin
          reg_rdata_o <= rev_word;
        end else if (rd_ctl) begin
          reg_rdata_o <= ctl_word;
        end else begin
          reg_rdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // field outputs

  assign ctrl_bulk_ratio_o      = ctrl_bulk_ratio;
  assign periodic_list_enable_o = periodic_list_enable;
  assign iso_enable_o           = iso_enable;
  assign control_list_enable_o  = control_list_enable;
  assign bulk_list_enable_o     = bulk_list_enable;
  assign functional_state_o     = functional_state;

endmodule : ohcirc_regs

// file: rtl/ohcirc_sof_timer.sv
`timescale 1ns/1ps

module ohcirc_sof_timer #(
  parameter int DELAY_CYCLES = ohcirc_pkg::SOF_DELAY_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // control
  input  wire logic start_i,
  input  wire logic abort_i,
  // status
  output logic      done_o,
  output logic      running_o
);

  localparam int CW = $clog2(DELAY_CYCLES + 1);

  generate
    if (DELAY_CYCLES < 1) begin : g_bad
      $error("ohcirc_sof_timer: DELAY_CYCLES must be at least 1");
    end
  endgenerate

  logic [CW-1:0] count;

  // abort beats start so a state left at once never fires
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count     <= '0;
      running_o <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        running_o <= 1'b0;
        count     <= '0;
      end else if (start_i) begin
        running_o <= 1'b1;
        count     <= CW'(DELAY_CYCLES - 1);
      end else if (running_o) begin
        if (count == '0) begin
          running_o <= 1'b0;
          done_o    <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule : ohcirc_sof_timer

// file: verification/ohcirc_regs_checker.sv
`timescale 1ns/1ps

module ohcirc_regs_checker #(
  parameter bit FIRST_FUNCTION   = 1'b1,
  parameter int SOF_DELAY_CYCLES = 8
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // requests
  input wire logic        soft_reset_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [3:0]  reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        resume_detected_i,
  input wire logic        event_irq_i,
  // answers
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        remote_wakeup_o,
  input wire logic        host_irq_o,
  input wire logic        smi_o,
  input wire logic        port_reset_o,
  input wire logic        sof_start_o,
  input wire logic [1:0]  functional_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_REV_READ: assert property (
    reg_rd_i && reg_addr_i[7:2] == 6'h0 |=>
    reg_rvalid_o && reg_rdata_o == {23'h0, FIRST_FUNCTION, 8'h10})
    else $error("revision read wrong");
  AST_NO_STRAY_VALID: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read answer without request");
  AST_IRQ_ROUTE: assert property (
    !$past(reset_i) |-> (host_irq_o || smi_o) == $past(event_irq_i) && !(host_irq_o && smi_o))
    else $error("interrupt routing wrong");
  AST_WAKE_CAUSE: assert property (remote_wakeup_o |-> $past(resume_detected_i))
    else $error("wake-up without resume");
  AST_SOFT_SUSPEND: assert property (soft_reset_i |=> functional_state_o == 2'h3)
    else $error("soft reset not suspend");
  AST_PORT_RESET: assert property (
    !$past(reset_i) |-> port_reset_o == ($past(functional_state_o) == 2'h0))
    else $error("port reset mismatch");
  AST_STATE_WRITE: assert property (
    reg_wr_i && reg_be_i[0] && !soft_reset_i && reg_addr_i[7:2] == 6'h1 |=>
    functional_state_o == $past(reg_wdata_i[7:6]))
    else $error("state write lost");
  AST_SOF_AFTER_OP: assert property (
    sof_start_o |-> functional_state_o == 2'h2 &&
    $past(functional_state_o, SOF_DELAY_CYCLES) == 2'h2)
    else $error("frame start too early");

  // main scenarios reached
  cover property (sof_start_o);
  cover property (smi_o);
  cover property (remote_wakeup_o);
endmodule : ohcirc_regs_checker

// file: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
  localparam int SOF = 8;
  logic        clk_i = 1'b0;
  logic        reset_i, soft_reset_i, reg_wr_i, reg_rd_i;
  logic        resume_detected_i, event_irq_i, port_resume_i;
  logic [7:0]  reg_addr_i;
  logic [3:0]  reg_be_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic        reg_rvalid_o, remote_wakeup_o, host_irq_o, smi_o, port_reset_o;
  logic        sof_start_o, sof_enable_o, periodic_list_enable_o, iso_enable_o;
  logic        control_list_enable_o, bulk_list_enable_o;
  logic [1:0]  ctrl_bulk_ratio_o, functional_state_o;
  int          mismatches, num_checks, n;

  always #20 clk_i = ~clk_i;

  ohcirc_regs #(.FIRST_FUNCTION(1'b1), .SOF_DELAY_CYCLES(SOF)) ohcirc_regs_i (.*);

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask : tick

  // reserved bits written zero by callers, except the all-ones write to the revision offset
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    n = 0;
    while (reg_rvalid_o !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) begin
      mismatches++;
      finish_test();
    end
    check(nm, reg_rdata_o, exp);
    // an idle edge keeps back-to-back reads from re-raising the strobe at once
    tick(1);
  endtask : rdc

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("state", functional_state_o, 2'h0);
    tick(1);
    check("port_reset", port_reset_o, 1'b1);
    rdc("rev", 8'h00, 32'h0000_0110);
    rdc("ctl", 8'h04, 32'h0000_0000);
    wr(8'h00, 32'hFFFF_FFFF);
    rdc("rev_ro", 8'h00, 32'h0000_0110);
    rdc("unmapped", 8'h08, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_states();
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, {24'h0, i[1:0], 6'h0});
      check("state", functional_state_o, i[1:0]);
      tick(1);
      check("port_reset", port_reset_o, i == 0);
    end
    $display("test states done");
  endtask : t_states

  task automatic t_route_wake();
    wr(8'h04, 32'h0000_04C0);
    event_irq_i = 1'b1;
    resume_detected_i = 1'b1;
    tick(2);
    check("host_irq", host_irq_o, 1'b1);
    check("smi", smi_o, 1'b0);
    check("wakeup", remote_wakeup_o, 1'b1);
    wr(8'h04, 32'h0000_01C0);
    tick(1);
    check("host_irq", host_irq_o, 1'b0);
    check("smi", smi_o, 1'b1);
    check("wakeup", remote_wakeup_o, 1'b0);
    event_irq_i = 1'b0;
    resume_detected_i = 1'b0;
    $display("test routing done");
  endtask : t_route_wake

  task automatic t_resets();
    wr(8'h04, 32'h0000_07BF);
    check("fields", {ctrl_bulk_ratio_o, periodic_list_enable_o, iso_enable_o,
                     control_list_enable_o, bulk_list_enable_o}, 32'h0000_003F);
    soft_reset_i = 1'b1;
    tick(1);
    soft_reset_i = 1'b0;
    rdc("soft", 8'h04, 32'h0000_03C0);
    port_resume_i = 1'b1;
    tick(1);
    port_resume_i = 1'b0;
    rdc("resume", 8'h04, 32'h0000_0340);
    reg_be_i = 4'h2;
    wr(8'h04, 32'h0000_0000);
    reg_be_i = 4'hF;
    rdc("lane", 8'h04, 32'h0000_0040);
    reset_i = 1'b1;
    tick(1);
    reset_i = 1'b0;
    rdc("hard", 8'h04, 32'h0000_0000);
    check("port_reset", port_reset_o, 1'b1);
    $display("test resets done");
  endtask : t_resets

  // timer shortened to SOF cycles; slack covers pipeline stages
  task automatic t_sof();
    wr(8'h04, 32'h0000_0080);
    n = 0;
    while (sof_start_o !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (n == 40) begin
      mismatches++;
      finish_test();
    end
    check("sof_delay", n >= SOF && n <= SOF + 3, 1'b1);
    check("sof_enable", sof_enable_o, 1'b1);
    wr(8'h04, 32'h0000_00C0);
    tick(1);
    check("sof_enable", sof_enable_o, 1'b0);
    $display("test frames done");
  endtask : t_sof

  initial begin
    mismatches = 0;
    num_checks = 0;
    reset_i = 1'b1;
    {soft_reset_i, reg_wr_i, reg_rd_i} = 3'h0;
    {resume_detected_i, event_irq_i, port_resume_i} = 3'h0;
    reg_addr_i = 8'h00;
    reg_be_i = 4'hF;
    reg_wdata_i = 32'h0000_0000;
    tick(6);
    reset_i = 1'b0;
    t_reset();
    t_states();
    t_route_wake();
    t_resets();
    t_sof();
    finish_test();
  end
endmodule : testbench

bind ohcirc_regs ohcirc_regs_checker #(
  .FIRST_FUNCTION(FIRST_FUNCTION), .SOF_DELAY_CYCLES(SOF_DELAY_CYCLES)
) ohcirc_regs_checker_i (.*);
